// [hw/mdx_pkg.sv]
package mdx_pkg;
  // register offsets on the plain register port (byte addresses)
  localparam logic [7:0] OFF_FAULT_ADDR = 8'h00;
  localparam logic [7:0] OFF_EVENT = 8'h04;
  localparam logic [7:0] OFF_PTE_HIGH = 8'h08;
  localparam logic [7:0] OFF_PTE_LOW = 8'h0C;
  localparam logic [7:0] OFF_PTE_ASSIST = 8'h10;
  localparam logic [7:0] OFF_SAVED_PC = 8'h14;
  localparam logic [7:0] OFF_SAVED_STATUS = 8'h18;
  localparam logic [7:0] OFF_SAVED_STACK = 8'h1C;
  localparam logic [7:0] OFF_VECTOR_BASE = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_MMU_CTRL = 8'h28;

  // exception event codes
  localparam logic [11:0] EVT_MULTI_HIT = 12'h140;
  localparam logic [11:0] EVT_MISS_READ = 12'h040;
  localparam logic [11:0] EVT_MISS_WRITE = 12'h060;
  localparam logic [11:0] EVT_PROT_READ = 12'h0A0;
  localparam logic [11:0] EVT_PROT_WRITE = 12'h0C0;
  localparam logic [11:0] EVT_INIT_WRITE = 12'h080;

  // branch targets
  localparam logic [31:0] RESET_VECTOR = 32'hA000_0000;
  localparam logic [31:0] MISS_OFFSET = 32'h0000_0400;
  localparam logic [31:0] PROT_OFFSET = 32'h0000_0100;

  // status register bits and reset value
  localparam int SR_MD = 30;
  localparam int SR_RB = 29;
  localparam int SR_BL = 28;
  localparam logic [31:0] SR_RESET = 32'h7000_00F0;

  // page entry field layout
  localparam int VPN_LSB = 10;
  localparam int PPN_MSB = 28;
  localparam int PPN_LSB = 10;
  localparam int PAGE_ENTRY_LOW_V = 8;
  localparam int PR_MSB = 6;
  localparam int PR_LSB = 5;
  localparam int PAGE_ENTRY_LOW_D = 2;
  localparam int ASSIST_MSB = 3;

  // mmu control: replace counter and replace boundary
  localparam int URC_LSB = 8;
  localparam int URB_LSB = 16;
  localparam int TLB_IDX_W = 6;
  localparam int TLB_ENTRIES = 64;
  localparam logic [5:0] URC_LAST = 6'h3F;

  // kind of data access
  typedef enum logic [2:0] {
    MDX_ACC_LOAD = 3'b000,
    MDX_ACC_STORE = 3'b001,
    MDX_ACC_PURGE = 3'b010,
    MDX_ACC_WRITEBACK = 3'b011,
    MDX_ACC_INVALIDATE = 3'b100,
    MDX_ACC_ALLOC_STORE = 3'b101
  } mdx_acc_t;

  // one unified tlb entry
  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic valid;
    logic dirty;
    logic [1:0] prot;
    logic [18:0] physical_page_number;
    logic [3:0] assist;
  } mdx_entry_t;
endpackage

// [hw/mdx_unit.sv]
`timescale 1ns/1ps
module mdx_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // data access from the load/store pipeline
  input wire logic acc_valid,
  input wire logic [2:0] acc_kind,
  input wire logic [31:0] acc_va,
  input wire logic [31:0] acc_pc,
  input wire logic [31:0] acc_branch_pc,
  input wire logic acc_delay_slot,
  input wire logic [31:0] acc_r15,
  // tlb load and instruction side refill search
  input wire logic load_tlb_instr_exec,
  input wire logic refill_req,
  input wire logic [31:0] refill_va,
  // access answers, one cycle after the request
  output logic acc_done,
  output logic [31:0] acc_pa,
  output logic acc_masked,
  output logic exc_taken,
  output logic [31:0] exc_vector,
  // refill answers
  output logic refill_done,
  output logic refill_hit,
  output logic [31:0] refill_pa
);
  typedef struct packed {
    // translation entries
    mdx_pkg::mdx_entry_t [mdx_pkg::TLB_ENTRIES-1:0] tlb;
    // captured fault context
    logic [31:0] fault_addr;
    logic [11:0] event_code;
    logic [31:0] pte_high;
    logic [31:0] pte_low;
    logic [3:0] pte_assist;
    logic [31:0] saved_pc;
    logic [31:0] saved_status;
    logic [31:0] saved_stack;
    // software control and status
    logic [31:0] vector_base;
    logic [31:0] status;
    // replace counter and boundary
    logic [5:0] replace_counter;
    logic [5:0] replace_boundary;
    // registered outputs
    logic [31:0] rdata;
    logic acc_done;
    logic [31:0] acc_pa;
    logic acc_masked;
    logic exc_taken;
    logic [31:0] exc_vector;
    logic refill_done;
    logic refill_hit;
    logic [31:0] refill_pa;
  } mdx_state_t;

  // present state and its next value
  mdx_state_t s;
  mdx_state_t next_s;
  // hit vectors and select chains of the data access and the refill
  logic [mdx_pkg::TLB_ENTRIES-1:0] data_hit;
  logic [mdx_pkg::TLB_ENTRIES-1:0] fill_hit;
  mdx_pkg::mdx_entry_t data_sel [mdx_pkg::TLB_ENTRIES:0];
  mdx_pkg::mdx_entry_t fill_sel [mdx_pkg::TLB_ENTRIES:0];

  // select chains start from an all-zero entry
  assign data_sel[0] = '0;
  assign fill_sel[0] = '0;

  // per entry compare and one-hot select of the matching entry
  generate
    for (genvar i = 0; i < mdx_pkg::TLB_ENTRIES; i++) begin : g_match
      assign data_hit[i] = s.tlb[i].valid && (s.tlb[i].virtual_page_number == acc_va[31:mdx_pkg::VPN_LSB]);
      assign fill_hit[i] = s.tlb[i].valid && (s.tlb[i].virtual_page_number == refill_va[31:mdx_pkg::VPN_LSB]);
      // or of all matching entries; exact only for a single hit
      assign data_sel[i+1] = data_sel[i] | (data_hit[i] ? s.tlb[i] : '0);
      assign fill_sel[i+1] = fill_sel[i] | (fill_hit[i] ? s.tlb[i] : '0);
    end
  endgenerate

  // match summary and access classification
  logic data_multi;
  logic fill_multi;
  logic acc_write;
  logic prot_ok;
  mdx_pkg::mdx_entry_t hit_entry;

  // more than one bit set in a hit vector
  assign data_multi = |(data_hit & (data_hit - 1'b1));
  assign fill_multi = |(fill_hit & (fill_hit - 1'b1));
  assign hit_entry = data_sel[mdx_pkg::TLB_ENTRIES];

  // cache operations classed as read or write
  always_comb begin
    case (acc_kind)
      mdx_pkg::MDX_ACC_STORE: acc_write = 1'b1;
      mdx_pkg::MDX_ACC_INVALIDATE: acc_write = 1'b1;
      mdx_pkg::MDX_ACC_ALLOC_STORE: acc_write = 1'b1;
      default: acc_write = 1'b0;
    endcase
  end

  // protection: bit 1 opens user access, bit 0 allows writes
  // privileged mode lifts only the user check, never the write check
  assign prot_ok = (s.status[mdx_pkg::SR_MD] || hit_entry.prot[1])
                   && (!acc_write || hit_entry.prot[0]);

  // next state
  always_comb begin
    logic [11:0] code;
    logic [31:0] offset;
    logic fault;
    // hold all state
    next_s = s;
    // fault kind defaults, overwritten below
    code = mdx_pkg::EVT_MISS_READ;
    offset = mdx_pkg::MISS_OFFSET;
    fault = 1'b0;
    // answer pulses and read data fall back to zero
    next_s.acc_done = 1'b0;
    next_s.acc_masked = 1'b0;
    next_s.exc_taken = 1'b0;
    next_s.refill_done = 1'b0;
    next_s.rdata = '0;

    // register read, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        mdx_pkg::OFF_FAULT_ADDR: next_s.rdata = s.fault_addr;
        mdx_pkg::OFF_EVENT: next_s.rdata = {20'h0_0000, s.event_code};
        mdx_pkg::OFF_PTE_HIGH: next_s.rdata = s.pte_high;
        mdx_pkg::OFF_PTE_LOW: next_s.rdata = s.pte_low;
        mdx_pkg::OFF_PTE_ASSIST: next_s.rdata = {28'h000_0000, s.pte_assist};
        mdx_pkg::OFF_SAVED_PC: next_s.rdata = s.saved_pc;
        mdx_pkg::OFF_SAVED_STATUS: next_s.rdata = s.saved_status;
        mdx_pkg::OFF_SAVED_STACK: next_s.rdata = s.saved_stack;
        mdx_pkg::OFF_VECTOR_BASE: next_s.rdata = s.vector_base;
        mdx_pkg::OFF_STATUS: next_s.rdata = s.status;
        mdx_pkg::OFF_MMU_CTRL: begin
          next_s.rdata[mdx_pkg::URC_LSB +: mdx_pkg::TLB_IDX_W] = s.replace_counter;
          next_s.rdata[mdx_pkg::URB_LSB +: mdx_pkg::TLB_IDX_W] = s.replace_boundary;
        end
        // unmapped offsets read as zero
        default: next_s.rdata = '0;
      endcase
    end

    // register write; hardware capture below overrides
    if (reg_wr) begin
      case (reg_addr)
        mdx_pkg::OFF_FAULT_ADDR: next_s.fault_addr = reg_wdata;
        mdx_pkg::OFF_EVENT: ; // read-only, written by capture only
        mdx_pkg::OFF_PTE_HIGH: next_s.pte_high = reg_wdata;
        mdx_pkg::OFF_PTE_LOW: next_s.pte_low = reg_wdata;
        mdx_pkg::OFF_PTE_ASSIST: next_s.pte_assist = reg_wdata[mdx_pkg::ASSIST_MSB:0];
        mdx_pkg::OFF_SAVED_PC: next_s.saved_pc = reg_wdata;
        mdx_pkg::OFF_SAVED_STATUS: next_s.saved_status = reg_wdata;
        mdx_pkg::OFF_SAVED_STACK: next_s.saved_stack = reg_wdata;
        mdx_pkg::OFF_VECTOR_BASE: next_s.vector_base = reg_wdata;
        mdx_pkg::OFF_STATUS: next_s.status = reg_wdata;
        mdx_pkg::OFF_MMU_CTRL: begin
          next_s.replace_counter = reg_wdata[mdx_pkg::URC_LSB +: mdx_pkg::TLB_IDX_W];
          next_s.replace_boundary = reg_wdata[mdx_pkg::URB_LSB +: mdx_pkg::TLB_IDX_W];
        end
        // writes to unmapped offsets are dropped
        default: ;
      endcase
    end

    // load tlb into the victim, then step the counter up to the boundary
    if (load_tlb_instr_exec) begin
      next_s.tlb[s.replace_counter].virtual_page_number = s.pte_high[31:mdx_pkg::VPN_LSB];
      next_s.tlb[s.replace_counter].valid = s.pte_low[mdx_pkg::PAGE_ENTRY_LOW_V];
      next_s.tlb[s.replace_counter].dirty = s.pte_low[mdx_pkg::PAGE_ENTRY_LOW_D];
      next_s.tlb[s.replace_counter].prot = s.pte_low[mdx_pkg::PR_MSB:mdx_pkg::PR_LSB];
      next_s.tlb[s.replace_counter].physical_page_number = s.pte_low[mdx_pkg::PPN_MSB:mdx_pkg::PPN_LSB];
      next_s.tlb[s.replace_counter].assist = s.pte_assist;
      // counter wraps to zero at the boundary or past the last entry
      // a software counter write in the same cycle loses to this step
      if (s.replace_counter == s.replace_boundary || s.replace_counter == mdx_pkg::URC_LAST) begin
        next_s.replace_counter = '0;
      end else begin
        next_s.replace_counter = s.replace_counter + 6'h01;
      end
    end

    // refill search for the instruction side
    if (refill_req) begin
      // hit and address answers hold until the next completed search; refill_done is a one-cycle pulse
      next_s.refill_done = 1'b1;
      next_s.refill_hit = |fill_hit && !fill_multi;
      next_s.refill_pa = {3'h0, fill_sel[mdx_pkg::TLB_ENTRIES].physical_page_number,
                          refill_va[mdx_pkg::VPN_LSB-1:0]};
    end

    // data access, first condition found wins
    // only one condition is reported; a clean access translates
    if (acc_valid && data_multi) begin
      fault = 1'b1;
    end else if (acc_valid && !(|data_hit)) begin
      fault = 1'b1;
      code = acc_write ? mdx_pkg::EVT_MISS_WRITE : mdx_pkg::EVT_MISS_READ;
      offset = mdx_pkg::MISS_OFFSET;
    end else if (acc_valid && !prot_ok) begin
      fault = 1'b1;
      code = acc_write ? mdx_pkg::EVT_PROT_WRITE : mdx_pkg::EVT_PROT_READ;
      offset = mdx_pkg::PROT_OFFSET;
    end else if (acc_valid && acc_write && !hit_entry.dirty) begin
      fault = 1'b1;
      code = mdx_pkg::EVT_INIT_WRITE;
      offset = mdx_pkg::PROT_OFFSET;
    end else if (acc_valid) begin
      next_s.acc_done = 1'b1;
      next_s.acc_pa = {3'h0, hit_entry.physical_page_number, acc_va[mdx_pkg::VPN_LSB-1:0]};
    end

    // multiple hit behaves as a reset; no coherency or entry repair done
    // a data multiple hit takes precedence over a refill of the same cycle
    if ((acc_valid && data_multi) || (refill_req && fill_multi && !fault)) begin
      next_s.fault_addr = (acc_valid && data_multi) ? acc_va : refill_va;
      next_s.event_code = mdx_pkg::EVT_MULTI_HIT;
      next_s.status = mdx_pkg::SR_RESET;
      next_s.exc_vector = mdx_pkg::RESET_VECTOR;
      next_s.exc_taken = 1'b1;
      // a reset drops the acc_done and refill_done answers of the same cycle
      next_s.refill_done = 1'b0;
      next_s.acc_done = 1'b0;
      // refill answers keep their last completed values
      next_s.refill_hit = s.refill_hit;
      next_s.refill_pa = s.refill_pa;
    end else if (fault && s.status[mdx_pkg::SR_BL]) begin
      // nothing is captured for a blocked fault
      next_s.acc_masked = 1'b1; // blocked while handler runs
    end else if (fault) begin
      // capture context, then enter privileged, blocked, bank one
      next_s.pte_high[31:mdx_pkg::VPN_LSB] = acc_va[31:mdx_pkg::VPN_LSB];
      next_s.fault_addr = acc_va;
      next_s.event_code = code;
      next_s.saved_pc = acc_delay_slot ? acc_branch_pc : acc_pc;
      next_s.saved_status = s.status;
      next_s.saved_stack = acc_r15;
      next_s.status[mdx_pkg::SR_MD] = 1'b1;
      next_s.status[mdx_pkg::SR_BL] = 1'b1;
      next_s.status[mdx_pkg::SR_RB] = 1'b1;
      // offset chosen above by the kind of fault
      next_s.exc_vector = s.vector_base + offset;
      next_s.exc_taken = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // all entries invalid; status comes up privileged and blocked
      s <= '0;
      s.status <= mdx_pkg::SR_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign reg_rdata = s.rdata;
  assign acc_done = s.acc_done;
  assign acc_pa = s.acc_pa;
  assign acc_masked = s.acc_masked;
  assign exc_taken = s.exc_taken;
  assign exc_vector = s.exc_vector;
  assign refill_done = s.refill_done;
  assign refill_hit = s.refill_hit;
  assign refill_pa = s.refill_pa;
endmodule // mdx_unit

// [bench/mdx_unit_properties.sv]
`timescale 1ns/1ps
module mdx_unit_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic [31:0] acc_va,
  input wire logic refill_req,
  input wire logic acc_done,
  input wire logic [31:0] acc_pa,
  input wire logic acc_masked,
  input wire logic exc_taken,
  input wire logic [31:0] exc_vector,
  input wire logic refill_done,
  input wire logic [31:0] refill_pa
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // answers follow requests one cycle later
  chk_one_answer: assert property (acc_valid |=> $onehot({acc_done, exc_taken, acc_masked}))
    else $error("access without exactly one answer");
  chk_quiet_idle: assert property (!acc_valid && !refill_req |=> !acc_done && !exc_taken)
    else $error("answer without request");
  chk_taken_cause: assert property (exc_taken |-> $past(acc_valid) || $past(refill_req))
    else $error("exception without cause");
  chk_vector_hold: assert property (!exc_taken |-> $stable(exc_vector))
    else $error("vector moved without exception");
  chk_masked_vector: assert property (acc_masked |-> $stable(exc_vector))
    else $error("masked fault changed vector");
  chk_pa_offset: assert property (acc_done |-> acc_pa[9:0] == $past(acc_va[9:0]))
    else $error("page offset not kept");
  chk_refill_answer: assert property (refill_req |=> refill_done || exc_taken)
    else $error("refill not answered");
  chk_refill_quiet: assert property (!refill_req |=> !refill_done)
    else $error("refill done without request");
  chk_refill_pa_hold: assert property (!refill_done |-> $stable(refill_pa))
    else $error("refill address moved");
endmodule // mdx_unit_properties

bind mdx_unit mdx_unit_properties mdx_unit_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
  .acc_valid(acc_valid), .acc_va(acc_va), .refill_req(refill_req), .acc_done(acc_done),
  .acc_pa(acc_pa), .acc_masked(acc_masked), .exc_taken(exc_taken), .exc_vector(exc_vector),
  .refill_done(refill_done), .refill_pa(refill_pa));

// [bench/mdx_core_model.sv]
`timescale 1ns/1ps
// handler software: register port and tlb load
module mdx_core_model (
  input wire logic core_clk,
  input wire logic [31:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic load_tlb_instr_exec
);
  // idle levels
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    load_tlb_instr_exec = 1'b0;
  end
  // one write; released data inverted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one read; data taken in the next cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // refill: entry words, victim choice, load, spare cycle
  task automatic load_entry(input logic [31:0] va, input logic [18:0] physical_page_number,
      input logic [1:0] prot, input logic d, input logic [5:0] replace_counter);
    wr(mdx_pkg::OFF_PTE_HIGH, va & 32'hFFFF_FC00);
    wr(mdx_pkg::OFF_PTE_LOW, {3'h0, physical_page_number, 3'b010, prot, 2'h0, d, 2'h0});
    wr(mdx_pkg::OFF_PTE_ASSIST, 32'h0000_0000);
    wr(mdx_pkg::OFF_MMU_CTRL, {10'h000, 6'h3F, 2'h0, replace_counter, 8'h00});
    @(posedge core_clk);
    load_tlb_instr_exec <= 1'b1;
    @(posedge core_clk);
    load_tlb_instr_exec <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule // mdx_core_model

// [bench/mdx_unit_tb.sv]
`timescale 1ns/1ps
module mdx_unit_tb;
  localparam logic [31:0] VB = 32'h8C00_0000;
  localparam logic [31:0] SRU = 32'h0000_00F0;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic core_clk, rst_n, reg_wr, reg_rd, load_tlb_instr_exec, acc_valid, acc_delay_slot, refill_req;
  logic acc_done, acc_masked, exc_taken, refill_done, refill_hit;
  logic [7:0] reg_addr;
  logic [2:0] acc_kind;
  logic [31:0] reg_wdata, reg_rdata, acc_va, acc_pc, acc_branch_pc, acc_r15, refill_va;
  logic [31:0] acc_pa, exc_vector, refill_pa;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  mdx_unit mdx_unit_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_va(acc_va), .acc_pc(acc_pc),
    .acc_branch_pc(acc_branch_pc), .acc_delay_slot(acc_delay_slot), .acc_r15(acc_r15),
    .load_tlb_instr_exec(load_tlb_instr_exec), .refill_req(refill_req), .refill_va(refill_va),
    .acc_done(acc_done), .acc_pa(acc_pa), .acc_masked(acc_masked), .exc_taken(exc_taken),
    .exc_vector(exc_vector), .refill_done(refill_done), .refill_hit(refill_hit),
    .refill_pa(refill_pa));
  mdx_core_model sw (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .load_tlb_instr_exec(load_tlb_instr_exec));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    logic [31:0] d;
    sw.rd(a, d);
    chk(n, e & m, d & m);
  endtask
  // one access; outputs settled afterwards
  task automatic access(input logic [2:0] k, input logic [31:0] va, input logic ds);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    acc_kind <= k;
    acc_va <= va;
    acc_pc <= va ^ 32'h0000_1000;
    acc_branch_pc <= va ^ 32'h0000_2000;
    acc_delay_slot <= ds;
    acc_r15 <= ~va;
    @(posedge core_clk);
    acc_valid <= 1'b0;
    #1;
  endtask
  task automatic refill(input logic [31:0] va);
    @(posedge core_clk);
    refill_req <= 1'b1;
    refill_va <= va;
    @(posedge core_clk);
    refill_req <= 1'b0;
    #1;
  endtask
  task automatic exp_exc(input logic [11:0] c, input logic [31:0] v, input logic [31:0] va,
      input logic ds);
    chk("exc_taken", 32'h0000_0001, {31'h0000_0000, exc_taken});
    chk("exc_vector", v, exc_vector);
    rchk("event", mdx_pkg::OFF_EVENT, ALL, {20'h0_0000, c});
    rchk("fault_addr", mdx_pkg::OFF_FAULT_ADDR, ALL, va);
    if (c != mdx_pkg::EVT_MULTI_HIT) begin
      rchk("pte_high", mdx_pkg::OFF_PTE_HIGH, 32'hFFFF_FC00, va);
      rchk("saved_pc", mdx_pkg::OFF_SAVED_PC, ALL, va ^ {18'h0_0000, ds, ~ds, 12'h000});
      rchk("saved_status", mdx_pkg::OFF_SAVED_STATUS, ALL, SRU);
      rchk("saved_stack", mdx_pkg::OFF_SAVED_STACK, ALL, ~va);
      rchk("status", mdx_pkg::OFF_STATUS, 32'h7000_0000, ALL);
    end else begin
      rchk("status", mdx_pkg::OFF_STATUS, ALL, mdx_pkg::SR_RESET);
    end
    sw.wr(mdx_pkg::OFF_STATUS, SRU);
  endtask
  task automatic exp_done(input logic [31:0] pa);
    chk("acc_done", 32'h0000_0001, {31'h0000_0000, acc_done});
    chk("acc_pa", pa, acc_pa);
  endtask
  // fault with the block bit set out of reset is dropped
  task automatic t_masked;
    access(mdx_pkg::MDX_ACC_LOAD, 32'h5555_0004, 1'b0);
    chk("acc_masked", 32'h0000_0001, {31'h0000_0000, acc_masked});
    rchk("fault_addr", mdx_pkg::OFF_FAULT_ADDR, ALL, 32'h0000_0000);
    sw.wr(mdx_pkg::OFF_VECTOR_BASE, VB);
    sw.wr(mdx_pkg::OFF_STATUS, SRU);
  endtask
  // miss for every access kind, odd kinds in a delay slot
  task automatic t_miss;
    logic [31:0] va;
    for (int k = 0; k < 6; k++) begin
      va = 32'h1234_5014 + (k << 11);
      access(3'(k), va, k[0]);
      exp_exc((k == 1 || k >= 4) ? mdx_pkg::EVT_MISS_WRITE : mdx_pkg::EVT_MISS_READ,
        VB + mdx_pkg::MISS_OFFSET, va, k[0]);
    end
  endtask
  // loaded entry translates accesses and refill searches
  task automatic t_hit;
    sw.load_entry(32'h4000_1000, 19'h1_2345, 2'b11, 1'b1, 6'h00);
    access(mdx_pkg::MDX_ACC_STORE, 32'h4000_1123, 1'b0);
    exp_done({3'h0, 19'h1_2345, 10'h123});
    refill(32'h4000_1010);
    chk("refill_hit", 32'h0000_0001, {31'h0000_0000, refill_hit});
    chk("refill_pa", {3'h0, 19'h1_2345, 10'h010}, refill_pa);
  endtask
  // protection, initial write, then multiple hit
  task automatic t_prot_multi;
    sw.load_entry(32'h4000_2000, 19'h0_0002, 2'b10, 1'b0, 6'h01);
    sw.load_entry(32'h4000_3000, 19'h0_0003, 2'b00, 1'b1, 6'h02);
    sw.load_entry(32'h4000_4000, 19'h0_0004, 2'b11, 1'b0, 6'h03);
    access(mdx_pkg::MDX_ACC_INVALIDATE, 32'h4000_2000, 1'b0);
    exp_exc(mdx_pkg::EVT_PROT_WRITE, VB + mdx_pkg::PROT_OFFSET, 32'h4000_2000, 1'b0);
    access(mdx_pkg::MDX_ACC_WRITEBACK, 32'h4000_3008, 1'b1);
    exp_exc(mdx_pkg::EVT_PROT_READ, VB + mdx_pkg::PROT_OFFSET, 32'h4000_3008, 1'b1);
    access(mdx_pkg::MDX_ACC_ALLOC_STORE, 32'h4000_400C, 1'b0);
    exp_exc(mdx_pkg::EVT_INIT_WRITE, VB + mdx_pkg::PROT_OFFSET, 32'h4000_400C, 1'b0);
    access(mdx_pkg::MDX_ACC_PURGE, 32'h4000_4000, 1'b0);
    exp_done({3'h0, 19'h0_0004, 10'h000});
    sw.wr(mdx_pkg::OFF_STATUS, 32'h4000_00F0);
    access(mdx_pkg::MDX_ACC_WRITEBACK, 32'h4000_3008, 1'b0);
    exp_done({3'h0, 19'h0_0003, 10'h008});
    sw.wr(mdx_pkg::OFF_STATUS, SRU);
    sw.load_entry(32'h4000_4000, 19'h0_0004, 2'b00, 1'b1, 6'h04);
    access(mdx_pkg::MDX_ACC_STORE, 32'h4000_4010, 1'b0);
    exp_exc(mdx_pkg::EVT_MULTI_HIT, mdx_pkg::RESET_VECTOR, 32'h4000_4010, 1'b0);
    refill(32'h4000_4014);
    chk("refill_done", 32'h0000_0000, {31'h0000_0000, refill_done});
    chk("refill_vec", mdx_pkg::RESET_VECTOR, exc_vector);
    chk("refill_pa_kept", {3'h0, 19'h1_2345, 10'h010}, refill_pa);
    exp_exc(mdx_pkg::EVT_MULTI_HIT, mdx_pkg::RESET_VECTOR, 32'h4000_4014, 1'b0);
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      complete_run();
    end
  end
  // reset, then scenarios
  initial begin
    rst_n = 1'b0;
    acc_valid = 1'b0;
    acc_kind = 3'h0;
    acc_va = 32'h0000_0000;
    acc_pc = 32'h0000_0000;
    acc_branch_pc = 32'h0000_0000;
    acc_delay_slot = 1'b0;
    acc_r15 = 32'h0000_0000;
    refill_req = 1'b0;
    refill_va = 32'h0000_0000;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_masked();
    t_miss();
    t_hit();
    t_prot_multi();
    complete_run();
  end
endmodule // mdx_unit_tb
